// File: common/mrc_map.svh
// Purpose: constants of the microcontroller reset controller
// Assumes: included by bare name from the rtl and test files
// Notes: register byte address is index * 4 on the APB bus
//
// Overview of operation
// - a low level on the external reset pin puts the device in reset
// - a watchdog counter overflow also puts the device in reset
// - both sources act alike; execution starts from vector at 0000H/0001H
// - all pins float during reset and the following stabilization wait
// - pin high releases reset; execution starts after 2^15 system clocks
// - watchdog reset releases itself, then waits the same 2^15 clocks
// - reset ending stop mode keeps stop state during reset, pins still float
// - program counter loads from the vector; stack undefined; status word 02H
// - port output latches and pull-up option registers clear to 00H
// - port direction registers set to FFH so every pin is an input
// - clock control register becomes 02H, stabilization select 04H
// - inverter compares and buffers 0 to 2 become 0000H, the fourth 00FFH
// - dead time reload becomes FFH; inverter control and mode become 00H
// - byte timer counts and modes clear to 00H; their compares undefined
// - watch timer mode, watchdog clock select and watchdog mode clear
// - converter mode and input select clear; converter result undefined
// - serial mode, status and baud control clear; transmit shift undefined
// - serial receive buffer becomes FFH
`ifndef MRC_MAP_SVH
`define MRC_MAP_SVH

// ****************************************************************
// timing
// ****************************************************************
`define MRC_CLK_MHZ 100
`define MRC_STAB_EXP 15
`define MRC_STAB_CYCLES (1 << `MRC_STAB_EXP)
`define MRC_EXT_LOW_US 10
`define MRC_EXT_LOW_CYC (`MRC_EXT_LOW_US * `MRC_CLK_MHZ)

// ****************************************************************
// reset vector
// ****************************************************************
`define MRC_VEC_LO_ADDR 16'h0000
`define MRC_VEC_HI_ADDR 16'h0001

// ****************************************************************
// register indices
// ****************************************************************
`define MRC_IDX_W 6
`define MRC_IDX_PROCESSOR_STATUS_WORD 0
`define MRC_IDX_PORT_LATCH 1
`define MRC_IDX_PORT_DIRECTION 4
`define MRC_IDX_PORT0_PULLUP_OPTION 7
`define MRC_IDX_PORT2_PULLUP_OPTION 8
`define MRC_IDX_CPU_CLOCK_CONTROL 9
`define MRC_IDX_STABILIZATION_TIME_SELECT 10
`define MRC_IDX_INVERTER_COMPARE 11
`define MRC_IDX_INVERTER_COMPARE_BUFFER 15
`define MRC_IDX_DEAD_TIME_RELOAD 19
`define MRC_IDX_INVERTER_TIMER_CONTROL 20
`define MRC_IDX_INVERTER_TIMER_MODE 21
`define MRC_IDX_BYTE_TIMER_COUNT 22
`define MRC_IDX_BYTE_TIMER_COMPARE 25
`define MRC_IDX_BYTE_TIMER_MODE 28
`define MRC_IDX_WATCH_TIMER_MODE 31
`define MRC_IDX_WATCHDOG_CLOCK_SELECT 32
`define MRC_IDX_WATCHDOG_MODE 33
`define MRC_IDX_CONVERTER_MODE 34
`define MRC_IDX_CONVERTER_RESULT 35
`define MRC_IDX_CONVERTER_INPUT_SELECT 36
`define MRC_IDX_SERIAL_MODE_REG 37
`define MRC_IDX_SERIAL_STATUS_REG 38
`define MRC_IDX_BAUD_GENERATOR_CONTROL 39
`define MRC_IDX_SERIAL_TRANSMIT_SHIFT 40
`define MRC_IDX_SERIAL_RECEIVE_BUFFER 41
`define MRC_IDX_STACK_POINTER_REG 42
`define MRC_NUM_REGS 43
`define MRC_IDX_RESET_CAUSE 48
`define MRC_IDX_PROGRAM_COUNTER_REG 49
`define MRC_PORT_COUNT 3
`define MRC_TIMER_COUNT 3
`define MRC_WIDE_COUNT 4

// ****************************************************************
// reset values and fields
// ****************************************************************
`define MRC_RST_CLEAR 16'h0000
`define MRC_RST_STATUS_WORD 16'h0002
`define MRC_RST_CLOCK_CONTROL 16'h0002
`define MRC_RST_STAB_SELECT 16'h0004
`define MRC_RST_LOW_ONES 16'h00FF
`define MRC_MASK_BYTE 16'h00FF
`define MRC_MASK_WORD 16'hFFFF
`define MRC_CAUSE_EXT_BIT 0
`define MRC_CAUSE_WDT_BIT 1
`define MRC_CAUSE_STATE_LSB 4

`endif

// File: common/mrc_pkg.sv
// Purpose: types shared by the reset controller files
// Assumes: constants live in mrc_map.svh
// Notes: state codes are gray along reset, wait, fetch, run
package mrc_pkg;
    typedef enum logic [2:0] {
        MRC_ST_RESET = 3'b000,
        MRC_ST_STAB = 3'b001,
        MRC_ST_FETCH_LO = 3'b011,
        MRC_ST_FETCH_HI = 3'b010,
        MRC_ST_RUN = 3'b110
    } mrc_state_t;
    typedef logic [15:0] mrc_word_t;
endpackage

// File: common/mrc_seq_if.sv
// Purpose: signals between the register shell and the reset sequencer
// Assumes: one clock domain
// Notes: requests are on the controller clock already
`timescale 1ns/10ps
interface mrc_seq_if;
    import mrc_pkg::*;
    logic ext_req;
    logic wdt_req;
    logic stop_mode;
    logic core_rst;
    logic pins_hiz;
    logic retain;
    logic start;
    mrc_state_t state;
    modport seq (input ext_req, wdt_req, stop_mode,
                 output core_rst, pins_hiz, retain, start, state);
    modport ctl (output ext_req, wdt_req, stop_mode,
                 input core_rst, pins_hiz, retain, start, state);
endinterface

// File: rtl/mrc_reset_controller.sv
// Purpose: reset controller top with APB register file and pin control
// Assumes: vector memory answers VEC_DATA in the cycle VEC_ADDR is shown
// Notes: APB answers with zero wait states
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_reset_controller
    import mrc_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = `MRC_STAB_CYCLES
) (
    // clock and power-on reset
    input wire logic CLK,
    input wire logic RESET_N,
    // reset sources
    input wire logic RESET_PIN_N,
    input wire logic WDT_OVERFLOW,
    input wire logic STOP_MODE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // reset vector fetch
    output logic [15:0] VEC_ADDR,
    output logic VEC_RD,
    input wire logic [7:0] VEC_DATA,
    // core control
    output logic CORE_RESET_N,
    output logic CPU_START,
    output logic CPU_RUN,
    output logic [15:0] PROGRAM_COUNTER,
    output logic STOP_RETAIN,
    // port pins
    output logic PINS_HIZ,
    output logic [23:0] PORT_OUT,
    output logic [23:0] PORT_OE,
    output logic [23:0] PORT_PULLUP
);
    localparam int NREG = `MRC_NUM_REGS;
    localparam int IW = `MRC_IDX_W;

    // reset info per register: {has reset value, value}
    function automatic logic [16:0] reg_info(input int i);
        logic [16:0] r;
        r = {1'b1, `MRC_RST_CLEAR};
        if (i == `MRC_IDX_PROCESSOR_STATUS_WORD) r[15:0] = `MRC_RST_STATUS_WORD;
        if (i >= `MRC_IDX_PORT_DIRECTION && i < `MRC_IDX_PORT_DIRECTION + `MRC_PORT_COUNT)
            r[15:0] = `MRC_RST_LOW_ONES;
        if (i == `MRC_IDX_CPU_CLOCK_CONTROL) r[15:0] = `MRC_RST_CLOCK_CONTROL;
        if (i == `MRC_IDX_STABILIZATION_TIME_SELECT) r[15:0] = `MRC_RST_STAB_SELECT;
        if (i == `MRC_IDX_INVERTER_COMPARE + 3) r[15:0] = `MRC_RST_LOW_ONES;
        if (i == `MRC_IDX_INVERTER_COMPARE_BUFFER + 3) r[15:0] = `MRC_RST_LOW_ONES;
        if (i == `MRC_IDX_DEAD_TIME_RELOAD) r[15:0] = `MRC_RST_LOW_ONES;
        if (i == `MRC_IDX_SERIAL_RECEIVE_BUFFER) r[15:0] = `MRC_RST_LOW_ONES;
        if (i >= `MRC_IDX_BYTE_TIMER_COMPARE && i < `MRC_IDX_BYTE_TIMER_COMPARE + `MRC_TIMER_COUNT)
            r[16] = 1'b0;
        if (i == `MRC_IDX_CONVERTER_RESULT) r[16] = 1'b0;
        if (i == `MRC_IDX_SERIAL_TRANSMIT_SHIFT) r[16] = 1'b0;
        if (i == `MRC_IDX_STACK_POINTER_REG) r[16] = 1'b0;
        return r;
    endfunction

    // inverter compares and buffers hold 16 bits, the rest 8
    function automatic logic [15:0] reg_mask(input int i);
        logic [15:0] m;
        m = `MRC_MASK_BYTE;
        if (i >= `MRC_IDX_INVERTER_COMPARE && i < `MRC_IDX_INVERTER_COMPARE + `MRC_WIDE_COUNT)
            m = `MRC_MASK_WORD;
        if (i >= `MRC_IDX_INVERTER_COMPARE_BUFFER &&
            i < `MRC_IDX_INVERTER_COMPARE_BUFFER + `MRC_WIDE_COUNT)
            m = `MRC_MASK_WORD;
        return m;
    endfunction

    mrc_seq_if sq ();
    logic pin_s1_r;
    logic pin_s2_r;
    logic ext_flag_r;
    logic wdt_flag_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    mrc_word_t pc_r;
    logic start_r;
    mrc_word_t reg_q [NREG];

    // ****************************************************************
    // reset sources
    // ****************************************************************
    // pin starts as asserted so reset holds until the pin is seen high
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= RESET_PIN_N;
            pin_s2_r <= pin_s1_r;
        end
    end

    assign sq.ext_req = ~pin_s2_r;
    assign sq.wdt_req = WDT_OVERFLOW;
    assign sq.stop_mode = STOP_MODE;

    mrc_sequencer #(
        .STAB_CYCLES(STAB_CYCLES)
    ) u_seq (
        .clk(CLK),
        .reset_n(RESET_N),
        .sq(sq)
    );

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire [IW-1:0] idx = PADDR[7:2];
    wire hi_zero = (PADDR[11:8] == 4'h0);
    wire in_file = hi_zero & (idx < IW'(NREG));
    wire is_cause = hi_zero & (idx == IW'(`MRC_IDX_RESET_CAUSE));
    wire is_pc = hi_zero & (idx == IW'(`MRC_IDX_PROGRAM_COUNTER_REG));
    wire acc = PSEL & PENABLE;
    wire setup = PSEL & ~PENABLE;
    wire wr_file = acc & PWRITE & in_file;
    wire wr_cause = acc & PWRITE & is_cause;
    wire bad = ~(in_file | is_cause | is_pc) | (PWRITE & is_pc);
    // stop retention freezes the file while the pin is still low
    wire core_clr = sq.core_rst & ~sq.retain;

    assign PREADY = 1'b1;
    assign PSLVERR = acc & bad;

    // read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_file) rd_mux = {16'h0000, reg_q[idx]};
        if (is_pc) rd_mux = {16'h0000, pc_r};
        if (is_cause) begin
            rd_mux[`MRC_CAUSE_EXT_BIT] = ext_flag_r;
            rd_mux[`MRC_CAUSE_WDT_BIT] = wdt_flag_r;
            rd_mux[`MRC_CAUSE_STATE_LSB +: 3] = sq.state;
        end
    end

    // read data is captured in the setup cycle, shown in the access cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) prdata_r <= 32'h0000_0000;
        else if (setup) prdata_r <= rd_mux;
    end
    assign PRDATA = prdata_r;

    // ****************************************************************
    // register file
    // ****************************************************************
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        localparam logic [16:0] INFO = reg_info(i);
        localparam logic [15:0] MASK = reg_mask(i);
        wire we = wr_file & (idx == IW'(i));
        mrc_word_t q_r;
        if (INFO[16]) begin : g_rst
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) q_r <= INFO[15:0];
                else if (core_clr) q_r <= INFO[15:0];
                else if (we) q_r <= PWDATA[15:0] & MASK;
            end
        end else begin : g_raw
            always_ff @(posedge CLK) begin
                if (we) q_r <= PWDATA[15:0] & MASK;
            end
        end
        assign reg_q[i] = q_r;
    end

    // cause flags survive internal reset; a new event beats a clear
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ext_flag_r <= 1'b0;
            wdt_flag_r <= 1'b0;
        end else begin
            ext_flag_r <= sq.ext_req | (ext_flag_r & ~(wr_cause & PWDATA[`MRC_CAUSE_EXT_BIT]));
            wdt_flag_r <= sq.wdt_req | (wdt_flag_r & ~(wr_cause & PWDATA[`MRC_CAUSE_WDT_BIT]));
        end
    end

    // ****************************************************************
    // vector fetch and core start
    // ****************************************************************
    wire fetch_lo = (sq.state == MRC_ST_FETCH_LO);
    wire fetch_hi = (sq.state == MRC_ST_FETCH_HI);

    assign VEC_ADDR = fetch_hi ? `MRC_VEC_HI_ADDR : `MRC_VEC_LO_ADDR;
    assign VEC_RD = fetch_lo | fetch_hi;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pc_r <= 16'h0000;
            start_r <= 1'b0;
        end else begin
            if (fetch_lo) pc_r[7:0] <= VEC_DATA;
            if (fetch_hi) pc_r[15:8] <= VEC_DATA;
            start_r <= sq.start;
        end
    end

    assign PROGRAM_COUNTER = pc_r;
    assign CPU_START = start_r;
    assign CPU_RUN = (sq.state == MRC_ST_RUN);
    assign CORE_RESET_N = ~sq.core_rst;
    assign STOP_RETAIN = sq.retain;
    assign PINS_HIZ = sq.pins_hiz;

    // ****************************************************************
    // port pins
    // ****************************************************************
    for (genvar p = 0; p < `MRC_PORT_COUNT; p++) begin : g_port
        wire [7:0] dir = reg_q[`MRC_IDX_PORT_DIRECTION + p][7:0];
        assign PORT_OUT[p*8 +: 8] = reg_q[`MRC_IDX_PORT_LATCH + p][7:0];
        assign PORT_OE[p*8 +: 8] = ~dir & {8{~sq.pins_hiz}};
    end

    // pull-ups act only on input pins and never while floating
    assign PORT_PULLUP = {reg_q[`MRC_IDX_PORT2_PULLUP_OPTION][7:0], 8'h00,
                          reg_q[`MRC_IDX_PORT0_PULLUP_OPTION][7:0]}
                         & {reg_q[`MRC_IDX_PORT_DIRECTION + 2][7:0],
                            reg_q[`MRC_IDX_PORT_DIRECTION + 1][7:0],
                            reg_q[`MRC_IDX_PORT_DIRECTION][7:0]}
                         & {24{~sq.pins_hiz}};
endmodule

// File: rtl/mrc_sequencer.sv
// Purpose: reset state machine and stabilization counter
// Assumes: requests synchronous to clk; STAB_CYCLES at least 2
// Notes: any new request restarts from the reset state
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_sequencer
    import mrc_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = `MRC_STAB_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // shell side
    mrc_seq_if.seq sq
);
    localparam int CW = $clog2(STAB_CYCLES);
    localparam logic [CW-1:0] CNT_LAST = CW'(STAB_CYCLES - 1);

    mrc_state_t state_r;
    mrc_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic retain_r;
    logic retain_nxt;
    wire req = sq.ext_req | sq.wdt_req;
    wire in_run = (state_r == MRC_ST_RUN);

    // ****************************************************************
    // next state
    // ****************************************************************
    // a request wins over every state, so a pulse mid-wait restarts it
    always_comb begin
        state_nxt = state_r;
        if (req) begin
            state_nxt = MRC_ST_RESET;
        end else begin
            unique case (state_r)
                MRC_ST_RESET: state_nxt = MRC_ST_STAB;
                MRC_ST_STAB: state_nxt = (cnt_r == CNT_LAST) ? MRC_ST_FETCH_LO : MRC_ST_STAB;
                MRC_ST_FETCH_LO: state_nxt = MRC_ST_FETCH_HI;
                MRC_ST_FETCH_HI: state_nxt = MRC_ST_RUN;
                MRC_ST_RUN: state_nxt = MRC_ST_RUN;
                default: state_nxt = MRC_ST_RESET;
            endcase
        end
    end

    assign cnt_nxt = (state_r == MRC_ST_STAB) ? cnt_r + 1'b1 : '0;
    assign retain_nxt = req & ((sq.stop_mode & in_run) | retain_r);

    // state, counter and stop retention flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= MRC_ST_RESET;
            cnt_r <= '0;
            retain_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            retain_r <= retain_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // reset held through wait
    assign sq.core_rst = (state_r == MRC_ST_RESET) | (state_r == MRC_ST_STAB);
    assign sq.pins_hiz = ~in_run;
    assign sq.retain = retain_r;
    assign sq.start = (state_r == MRC_ST_FETCH_HI) & ~req;
    assign sq.state = state_r;
endmodule

// File: test/mrc_reset_controller_assertions.sv
// Purpose: port-level checks of the reset controller
// Assumes: bound to mrc_reset_controller, one clock domain
// Notes: cycle figures follow the sequencer timing of the hand-over
`timescale 1ns/10ps
module mrc_reset_controller_assertions #(
    parameter int unsigned STAB_CYCLES = 16
) (
    // clock, reset and sources
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic RESET_PIN_N,
    input wire logic WDT_OVERFLOW,
    // fetch and core side
    input wire logic [15:0] VEC_ADDR,
    input wire logic VEC_RD,
    input wire logic [7:0] VEC_DATA,
    input wire logic CORE_RESET_N,
    input wire logic CPU_START,
    input wire logic CPU_RUN,
    input wire logic [15:0] PROGRAM_COUNTER,
    input wire logic PINS_HIZ,
    input wire logic [23:0] PORT_OE
);
    logic [31:0] wdt_cnt_r;
    logic [31:0] ext_cnt_r;
    logic wdt_arm_r;
    logic ext_arm_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // cycles since each source last asked; the other source disarms the view
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wdt_cnt_r <= 32'h0;
            ext_cnt_r <= 32'h0;
            wdt_arm_r <= 1'b0;
            ext_arm_r <= 1'b0;
        end else begin
            wdt_cnt_r <= WDT_OVERFLOW ? 32'h0 : wdt_cnt_r + 32'h1;
            ext_cnt_r <= !RESET_PIN_N ? 32'h0 : ext_cnt_r + 32'h1;
            wdt_arm_r <= WDT_OVERFLOW || (wdt_arm_r && RESET_PIN_N);
            ext_arm_r <= !RESET_PIN_N || (ext_arm_r && !WDT_OVERFLOW);
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    property p_hiz_reset;
        !CORE_RESET_N |-> PINS_HIZ && PORT_OE == 24'h000000;
    endproperty
    a_hiz_reset: assert property (p_hiz_reset) else $error("pins driven in reset");
    property p_pin_reset;
        !RESET_PIN_N [*3] |=> !CORE_RESET_N && PINS_HIZ;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin low gave no reset");
    property p_wdt_reset;
        WDT_OVERFLOW |=> !CORE_RESET_N && !CPU_RUN;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("overflow gave no reset");
    property p_wdt_time;
        $rose(CPU_RUN) && wdt_arm_r |-> wdt_cnt_r == STAB_CYCLES + 3;
    endproperty
    a_wdt_time: assert property (p_wdt_time) else $error("watchdog restart time");
    property p_ext_time;
        $rose(CPU_RUN) && ext_arm_r |-> ext_cnt_r == STAB_CYCLES + 5;
    endproperty
    a_ext_time: assert property (p_ext_time) else $error("pin restart time");
    property p_fetch;
        $rose(VEC_RD) |-> VEC_ADDR == 16'h0000 ##1 VEC_RD && VEC_ADDR == 16'h0001
            ##1 CPU_START && CPU_RUN;
    endproperty
    a_fetch: assert property (p_fetch) else $error("vector fetch order");
    property p_pc_vector;
        $rose(CPU_RUN) |-> PROGRAM_COUNTER == {$past(VEC_DATA), $past(VEC_DATA, 2)};
    endproperty
    a_pc_vector: assert property (p_pc_vector) else $error("pc not from vector");
    property p_start;
        CPU_START |-> CPU_RUN && !PINS_HIZ ##1 !CPU_START;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_hiz_run;
        PINS_HIZ != CPU_RUN;
    endproperty
    a_hiz_run: assert property (p_hiz_run) else $error("pins float while running");
endmodule

bind mrc_reset_controller mrc_reset_controller_assertions #(.STAB_CYCLES(STAB_CYCLES)) i_chk (
    .CLK(CLK), .RESET_N(RESET_N), .RESET_PIN_N(RESET_PIN_N), .WDT_OVERFLOW(WDT_OVERFLOW),
    .VEC_ADDR(VEC_ADDR), .VEC_RD(VEC_RD), .VEC_DATA(VEC_DATA), .CORE_RESET_N(CORE_RESET_N),
    .CPU_START(CPU_START), .CPU_RUN(CPU_RUN), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .PINS_HIZ(PINS_HIZ), .PORT_OE(PORT_OE));

// File: test/mrc_reset_controller_tb_top.sv
// Purpose: self-checking bench of the reset controller
// Assumes: short stabilization count; vector memory modelled here
// Notes: expected answers queue up and a monitor drains them
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_reset_controller_tb_top;
    import mrc_pkg::*;
    localparam int unsigned STAB = 16;
    localparam logic [11:0] CAUSE = 12'(`MRC_IDX_RESET_CAUSE * 4);
    logic clk, reset_n, wdt, stop, src_req, pin_n, psel, penable, pwrite, pready, pslverr;
    logic vec_rd, core_rst_n, start, run, retain, hiz;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] vec_addr, pc, cur_pc;
    logic [7:0] vec_lo, vec_hi, vec_data;
    logic [23:0] port_out, port_oe, port_pu;
    logic [33:0] exp_q[$];
    mrc_word_t pc_q[$];
    logic [31:0] wv[42];
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'h6766;

    // vector memory answers in the same cycle
    assign vec_data = vec_addr[0] ? vec_hi : vec_lo;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    mrc_reset_controller #(.STAB_CYCLES(STAB)) i_dut (
        .CLK(clk), .RESET_N(reset_n), .RESET_PIN_N(pin_n), .WDT_OVERFLOW(wdt),
        .STOP_MODE(stop), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .VEC_ADDR(vec_addr), .VEC_RD(vec_rd), .VEC_DATA(vec_data), .CORE_RESET_N(core_rst_n),
        .CPU_START(start), .CPU_RUN(run), .PROGRAM_COUNTER(pc), .STOP_RETAIN(retain),
        .PINS_HIZ(hiz), .PORT_OUT(port_out), .PORT_OE(port_oe), .PORT_PULLUP(port_pu));

    mrc_reset_source i_src (.clk(clk), .reset_n(reset_n), .req(src_req), .pin_n(pin_n));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask

    // one idle edge first, so release and the next setup never share a step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic e, input logic [31:0] x);
        int n;
        exp_q.push_back({w, e, x});
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bit 32 marks a register with no defined reset value
    function automatic logic [32:0] rst_val(input int i);
        case (i)
            0, 9: return 33'h000000002;
            4, 5, 6, 14, 18, 19, 41: return 33'h0000000FF;
            10: return 33'h000000004;
            25, 26, 27, 35, 40: return 33'h100000000;
            default: return 33'h000000000;
        endcase
    endfunction

    task automatic rd_all();
        logic [32:0] v;
        for (int i = 0; i < 42; i++) begin
            v = rst_val(i);
            if (!v[32]) apb(12'(i * 4), 1'b0, 32'h0, 1'b0, v[31:0]);
        end
    endtask

    task automatic wr_all();
        logic [31:0] r;
        for (int i = 0; i < 42; i++) begin
            r = $random(seed);
            wv[i] = r & ((i > 10 && i < 19) ? 32'h0000FFFF : 32'h000000FF);
            apb(12'(i * 4), 1'b1, r, 1'b0, 32'h0);
            apb(12'(i * 4), 1'b0, 32'h0, 1'b0, wv[i]);
        end
    endtask

    task automatic new_vec();
        logic [31:0] r;
        r = $random(seed);
        vec_lo <= r[7:0];
        vec_hi <= r[15:8];
        cur_pc = r[15:0];
        pc_q.push_back(r[15:0]);
    endtask

    task automatic wait_run(input logic lvl);
        int n;
        n = 0;
        while (run !== lvl && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (run !== lvl) begin
            chk("cpu_run", 32'(lvl), 32'(run));
            end_of_test();
        end
    endtask

    // monitor: each answer or start pulse takes the oldest note
    always @(posedge clk) begin
        logic [33:0] e;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = exp_q.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (e[33:32] === 2'b00) chk("prdata", e[31:0], prdata);
        end
        if (start === 1'b1) chk("program_counter", {16'h0, pc_q.pop_front()}, {16'h0, pc});
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        reset_n = 1'b0;
        wdt = 1'b0;
        stop = 1'b0;
        src_req = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        new_vec();
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        wait_run(1'b1);
        rd_all();
        apb(CAUSE, 1'b0, 32'h0, 1'b0, {25'h0, MRC_ST_RUN, 4'h1});
        apb(12'(`MRC_IDX_PROGRAM_COUNTER_REG * 4), 1'b0, 32'h0, 1'b0, {16'h0, cur_pc});
        apb(12'h0B4, 1'b0, 32'h0, 1'b1, 32'h0);
        apb(12'h104, 1'b0, 32'h0, 1'b1, 32'h0);
        apb(12'(`MRC_IDX_PROGRAM_COUNTER_REG * 4), 1'b1, 32'h1234, 1'b1, 32'h0);
        chk("port_oe", 32'h0, {8'h0, port_oe});
        chk("port_out", 32'h0, {8'h0, port_out});
        wr_all();
        chk("port_pullup", (wv[8] << 16 | wv[7]) & (wv[6] << 16 | wv[5] << 8 | wv[4]),
            32'(port_pu));
        apb(CAUSE, 1'b1, 32'h3, 1'b0, 32'h0);
        apb(CAUSE, 1'b0, 32'h0, 1'b0, {25'h0, MRC_ST_RUN, 4'h0});
        // watchdog pulse, then a write that reset must swallow
        new_vec();
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        apb(12'h024, 1'b1, 32'h55, 1'b0, 32'h0);
        wait_run(1'b1);
        rd_all();
        apb(CAUSE, 1'b0, 32'h0, 1'b0, {25'h0, MRC_ST_RUN, 4'h2});
        // pin reset out of stop keeps the file until the wait starts
        wr_all();
        stop <= 1'b1;
        new_vec();
        src_req <= 1'b1;
        @(posedge clk);
        src_req <= 1'b0;
        wait_run(1'b0);
        repeat (4) @(posedge clk);
        chk("stop_retain", 32'h1, 32'(retain));
        apb(12'h04C, 1'b0, 32'h0, 1'b0, wv[19]);
        stop <= 1'b0;
        wait_run(1'b1);
        rd_all();
        // second power-on reset in mid-run
        new_vec();
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wait_run(1'b1);
        apb(CAUSE, 1'b0, 32'h0, 1'b0, {25'h0, MRC_ST_RUN, 4'h1});
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule

// File: test/mrc_reset_source.sv
// Purpose: board reset source that drives the reset pin
// Assumes: req is a pulse or level on the system clock
// Notes: a short request is stretched, so a longer one is the slow case
`timescale 1ns/10ps
`include "mrc_map.svh"
module mrc_reset_source #(
    parameter int unsigned LOW_CYC = `MRC_EXT_LOW_CYC
) (
    // clock and control
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req,
    // reset pin
    output logic pin_n
);
    int unsigned low_cnt_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_n <= 1'b1;
            low_cnt_r <= 0;
        end else if (req && pin_n) begin
            pin_n <= 1'b0;
            low_cnt_r <= 1;
        end else if (!pin_n && (low_cnt_r < LOW_CYC || req)) begin
            low_cnt_r <= low_cnt_r + 1;
        end else begin
            pin_n <= 1'b1;
        end
    end
endmodule
